// ### design/coupler_pkg.sv
package coupler_pkg;
	localparam int unsigned CLK_HZ       = 100_000_000;
	localparam int unsigned PULSE_MS     = 20;
	localparam int unsigned WINDOW_MS    = 30;
	localparam int unsigned GAP_MS       = 35;
	localparam int unsigned PULSE_CYC    = CLK_HZ / 1000 * PULSE_MS;
	localparam int unsigned WINDOW_CYC   = CLK_HZ / 1000 * WINDOW_MS;
	localparam int unsigned GAP_CYC      = CLK_HZ / 1000 * GAP_MS;
	localparam int unsigned ADDR_W       = 5;
	localparam int unsigned CNT_W        = 32;
	// unit address bits, index 4 is the highest
	localparam logic [4:0]  UNIT1_ADDR   = 5'h10;
	localparam logic [4:0]  UNIT2_ADDR   = 5'h08;
	localparam logic [4:0]  UNIT3_ADDR   = 5'h18;
endpackage : coupler_pkg

// ### design/oneshot_timer.sv
module oneshot_timer #(
	parameter int unsigned CYCLES = 2
) (
	input  wire logic clk_sys,
	input  wire logic reset,
	input  wire logic phase,
	input  wire logic fire,
	output logic      running
);
	logic [coupler_pkg::CNT_W-1:0] count_q;

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			count_q <= '0;
			running <= 1'b0;
		end
		else if (phase)
		begin
			if (fire && !running)
			begin
				count_q <= coupler_pkg::CNT_W'(CYCLES - 1);
				running <= 1'b1;
			end
			else if (running)
			begin
				if (count_q == '0)
					running <= 1'b0;
				else
					count_q <= count_q - 1'b1;
			end
		end
	end
endmodule : oneshot_timer

// ### design/typewriter_coupler_sequencer.sv
module typewriter_coupler_sequencer #(
	parameter logic [4:0]  UNIT_ADDR  = coupler_pkg::UNIT1_ADDR,
	parameter int unsigned PULSE_CYC  = coupler_pkg::PULSE_CYC,
	parameter int unsigned WINDOW_CYC = coupler_pkg::WINDOW_CYC,
	parameter int unsigned GAP_CYC    = coupler_pkg::GAP_CYC
) (
	input  wire logic       clk_sys,
	input  wire logic       reset,
	input  wire logic       system_clock_phase,
	input  wire logic [4:0] unit_address_bits,
	input  wire logic       direction_bit,
	input  wire logic       char_empty_flag,
	input  wire logic [6:1] char_register_bits,
	input  wire logic       char_parity_bit,
	input  wire logic       key_common_contact,
	input  wire logic       interlock_ready,
	input  wire logic [6:1] key_code_lines,
	input  wire logic       key_parity_line,
	output logic            coupler_select,
	output logic            input_lamp_drive,
	output logic            buffer_clock_out_n,
	output logic [6:1]      buffer_data_inputs_n,
	output logic            buffer_parity_input_n,
	output logic            common_print_driver,
	output logic [5:0]      coded_print_drivers,
	output logic            backspace_driver,
	output logic            space_driver,
	output logic            tab_driver,
	output logic            return_driver,
	output logic            upshift_driver,
	output logic            upper_case_flag
);
	////////////////////////////////////////////////////////////////////////////
	logic buffer_clock_ff_q;
	logic case_hold_ff_q;
	logic pulse_run;
	logic window_run;
	logic gap_run;
	wire  [6:1] r = char_register_bits;

	// address chosen per unit by parameter
	wire sel = (unit_address_bits == UNIT_ADDR);
	wire dir_out = direction_bit;
	wire q2 = system_clock_phase;

	wire func_pat = r[3] & ~r[4] & r[5] & ~r[6];
	wire upper = dir_out & ((r[3] & r[4]) | (r[1] & func_pat));

	wire fire_in  = ~dir_out & key_common_contact;
	wire fire_out = dir_out & ~key_common_contact & interlock_ready;
	// gap must expire before next cycle
	wire fire_pulse = sel & ~char_empty_flag & ~window_run & ~gap_run
		& ~pulse_run & (fire_in | fire_out);

	wire fire_window = pulse_run & (~case_hold_ff_q | ~buffer_clock_ff_q);
	wire fire_gap = window_run & ~pulse_run
		& (buffer_clock_ff_q | (upper & ~case_hold_ff_q));

	// set buffer clock after pulse end
	wire set_bclk = sel & ~pulse_run & window_run & ~gap_run
		& (~upper | case_hold_ff_q) & ~buffer_clock_ff_q;
	// clear after window end or deselect
	wire clr_bclk = (gap_run & ~window_run & ~case_hold_ff_q) | ~sel;

	wire set_hold = sel & upper & window_run & gap_run & ~buffer_clock_ff_q
		& ~case_hold_ff_q;
	// hold cleared as third pulse fires
	wire clr_hold = (pulse_run & buffer_clock_ff_q) | ~sel;

	wire print_gate = sel & dir_out & pulse_run & ~key_common_contact
		& (case_hold_ff_q | ~upper) & ~buffer_clock_ff_q & ~func_pat
		& (|{r, char_parity_bit});
	wire function_gate = sel & dir_out & func_pat & pulse_run & ~case_hold_ff_q
		& ~buffer_clock_ff_q & ~key_common_contact;

	wire [5:0] coded = {
		print_gate & ~(r[1] ^ r[2]),
		print_gate & ~r[2],
		print_gate & ~r[3],
		print_gate & ~r[3] & ~r[4],
		print_gate & ~r[5],
		print_gate & (r[3] ^ r[6])};

	wire gate_in = buffer_clock_ff_q & ~dir_out;
	wire bclk = buffer_clock_ff_q & ~case_hold_ff_q & gap_run;

	////////////////////////////////////////////////////////////////////////////
	// phase-enabled one-shots
	oneshot_timer #(.CYCLES(PULSE_CYC)) u_pulse (
		.clk_sys (clk_sys),
		.reset   (reset),
		.phase   (q2),
		.fire    (fire_pulse),
		.running (pulse_run)
	);

	oneshot_timer #(.CYCLES(WINDOW_CYC)) u_window (
		.clk_sys (clk_sys),
		.reset   (reset),
		.phase   (q2),
		.fire    (fire_window),
		.running (window_run)
	);

	// gap timer also paces the upper-case shift cycle
	oneshot_timer #(.CYCLES(GAP_CYC)) u_gap (
		.clk_sys (clk_sys),
		.reset   (reset),
		.phase   (q2),
		.fire    (fire_gap),
		.running (gap_run)
	);

	////////////////////////////////////////////////////////////////////////////
	// two-flop case counter
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			buffer_clock_ff_q <= 1'b0;
			case_hold_ff_q    <= 1'b0;
		end
		else if (q2)
		begin
			if (set_bclk)
				buffer_clock_ff_q <= 1'b1;
			else if (clr_bclk)
				buffer_clock_ff_q <= 1'b0;
			if (set_hold)
				case_hold_ff_q <= 1'b1;
			else if (clr_hold)
				case_hold_ff_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs registered; adds one cycle to every drive
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			coupler_select        <= 1'b0;
			input_lamp_drive      <= 1'b0;
			buffer_clock_out_n    <= 1'b1;
			buffer_data_inputs_n  <= '1;
			buffer_parity_input_n <= 1'b1;
			common_print_driver   <= 1'b0;
			coded_print_drivers   <= '0;
			backspace_driver      <= 1'b0;
			space_driver          <= 1'b0;
			tab_driver            <= 1'b0;
			return_driver         <= 1'b0;
			upshift_driver        <= 1'b0;
			upper_case_flag       <= 1'b0;
		end
		else
		begin
			coupler_select        <= sel;
			input_lamp_drive      <= sel & ~dir_out & ~char_empty_flag;
			buffer_clock_out_n    <= ~bclk;
			buffer_data_inputs_n  <= ~({6{gate_in}} & key_code_lines);
			buffer_parity_input_n <= ~(gate_in & key_parity_line);
			common_print_driver   <= print_gate;
			coded_print_drivers   <= coded;
			backspace_driver      <= function_gate & ~r[1] & r[2];
			space_driver          <= function_gate & ~r[1] & ~r[2];
			tab_driver            <= function_gate & r[1] & r[2];
			return_driver         <= function_gate & r[1] & ~r[2];
			upshift_driver        <= upper & ~buffer_clock_ff_q & r[4] & sel;
			upper_case_flag       <= upper;
		end
	end
endmodule : typewriter_coupler_sequencer

// ### test/coupler_assertions.sv
module coupler_assertions #(
	parameter logic [4:0] UNIT_ADDR = 5'h10
) (
	input wire logic       clk_sys,
	input wire logic       reset,
	input wire logic [4:0] unit_address_bits,
	input wire logic       direction_bit,
	input wire logic [6:1] char_register_bits,
	input wire logic       char_parity_bit,
	input wire logic       key_common_contact,
	input wire logic       coupler_select,
	input wire logic       common_print_driver,
	input wire logic [5:0] coded_print_drivers,
	input wire logic       space_driver,
	input wire logic       backspace_driver,
	input wire logic       tab_driver,
	input wire logic       return_driver,
	input wire logic       upshift_driver,
	input wire logic       upper_case_flag
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);
	logic [6:1] r;
	logic [5:0] map_w;
	logic       sh_w;
	assign r = char_register_bits;
	assign map_w = {~(r[1] ^ r[2]), ~r[2], ~r[3], ~r[3] & ~r[4], ~r[5], r[3] ^ r[6]};
	assign sh_w = direction_bit && r[3] && (r[4] || {r[6:4], r[1]} == 4'h5);
	//////////////////////////////////////////////////
	a_select_decode: assert property (!$past(reset) |->
		coupler_select == ($past(unit_address_bits) == UNIT_ADDR)) else $error("select");
	a_print_qualified: assert property (common_print_driver |-> $past(direction_bit) &&
		!$past(key_common_contact) && $past({r, char_parity_bit}) != 7'h00) else $error("print");
	a_coded_translate: assert property (!$past(reset) |-> coded_print_drivers ==
		(common_print_driver ? $past(map_w) : 6'h00)) else $error("coded");
	a_function_pick: assert property (space_driver || backspace_driver |->
		$past(r) == {4'h5, backspace_driver, 1'b0}) else $error("space");
	a_tab_return: assert property (tab_driver || return_driver |->
		$past(r) == {4'h5, tab_driver, 1'b1}) else $error("tab");
	a_gate_exclusive: assert property (common_print_driver |->
		!(space_driver || backspace_driver || tab_driver || return_driver)) else $error("excl");
	a_upshift_cause: assert property (upshift_driver |->
		$past(direction_bit && r[3] && r[4])) else $error("upshift");
	a_case_flag: assert property (!$past(reset) && $past(unit_address_bits) == UNIT_ADDR |->
		upper_case_flag == $past(sh_w)) else $error("case");
	c_upper_print: cover property (upshift_driver && common_print_driver);
	c_tab: cover property (tab_driver);
	c_space: cover property (space_driver);
endmodule : coupler_assertions
bind typewriter_coupler_sequencer coupler_assertions #(.UNIT_ADDR(UNIT_ADDR)) u_coupler_assertions (.*);

// ### test/typewriter_model.sv
module typewriter_model (
	input  wire logic       clk_sys,
	input  wire logic       reset,
	input  wire logic       drive,
	input  wire logic       key_req,
	input  wire logic [6:0] key_val,
	output logic            contact,
	output logic            ready,
	output logic [6:0]      key_lines
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [5:0] busy_q;
	logic [6:0] val_q;
	always_ff @(posedge clk_sys)
	begin
		busy_q <= reset ? 6'h00 : busy_q != 6'h00 ? busy_q - 6'h01 : (drive || key_req) ? 6'h3F : 6'h00;
		if (busy_q == 6'h00)
			val_q <= key_req ? key_val : 7'h00;
	end
	assign ready = busy_q == 6'h00;
	// contact closes late, like a slow typebar
	assign contact = busy_q > 6'h02 && busy_q < 6'h3B;
	// open contacts read as the pull-down level
	assign key_lines = contact ? val_q : 7'h00;
endmodule : typewriter_model

// ### test/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic       clk_sys = 0, reset = 1, dir = 0, empty = 1, key_req = 0, phase = 0, clr_seen = 0;
	logic [4:0] addr = 5'h10;
	logic [6:1] ch = 6'h00;
	logic [6:0] kval = 7'h00, klines, data_n;
	logic [5:0] coded, cap, seen = 6'h00;
	logic       sel, lamp, clk_n, cpd, sp, bs, tb, cr, up, contact, ready, ucf;
	int         err_total = 0, n_compared = 0, cyc = 0, t;
	logic [6:1] chars[7] = '{6'h01, 6'h00, 6'h14, 6'h16, 6'h0C, 6'h17, 6'h15};
	logic [6:0] exps[7] = '{7'h10, 7'h00, 7'h08, 7'h04, 7'h70, 7'h42, 7'h41};
	typewriter_coupler_sequencer #(.PULSE_CYC(10), .WINDOW_CYC(15), .GAP_CYC(20))
		u_typewriter_coupler_sequencer (.clk_sys(clk_sys), .reset(reset),
		.system_clock_phase(phase), .unit_address_bits(addr), .direction_bit(dir),
		.char_empty_flag(empty), .char_register_bits(ch), .char_parity_bit(~^ch & |ch),
		.key_common_contact(contact), .interlock_ready(ready), .key_code_lines(klines[5:0]),
		.key_parity_line(klines[6]), .coupler_select(sel), .input_lamp_drive(lamp),
		.buffer_clock_out_n(clk_n), .buffer_data_inputs_n(data_n[5:0]),
		.buffer_parity_input_n(data_n[6]), .common_print_driver(cpd),
		.coded_print_drivers(coded), .backspace_driver(bs), .space_driver(sp),
		.tab_driver(tb), .return_driver(cr), .upshift_driver(up), .upper_case_flag(ucf));
	typewriter_model u_typewriter_model (.clk_sys(clk_sys), .reset(reset),
		.drive(cpd | sp | bs | tb | cr), .key_req(key_req), .key_val(kval),
		.contact(contact), .ready(ready), .key_lines(klines));
	initial forever #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys)
	begin
		seen <= clr_seen ? 6'h00 : seen | {up, cpd, sp, bs, tb, cr};
		// phase enable every other cycle so the timers really depend on it
		phase <= ~phase;
		cap <= cpd ? coded : cap;
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			err_total++;
			print_verdict();
		end
	end
	//////////////////////////////////////////////////
	task step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : step
	task chk(input string name, input logic [7:0] s, e);
		n_compared++;
		if (s !== e)
		begin
			err_total++;
			$display("Error %s expected %h seen %h", name, e, s);
		end
	endtask : chk
	task print_verdict;
		if (err_total == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : print_verdict
	function automatic logic [5:0] code_map(input logic [6:1] r);
		return {~(r[1] ^ r[2]), ~r[2], ~r[3], ~r[3] & ~r[4], ~r[5], r[3] ^ r[6]};
	endfunction : code_map
	//////////////////////////////////////////////////
	initial
	begin
		step(16);
		reset = 0;
		for (int a = 0; a < 32; a++)
		begin
			addr = a[4:0];
			step(2);
			chk("select", sel, a == 16);
		end
		addr = 5'h10;
		empty = 0;
		step(2);
		chk("lamp", lamp, 8'h01);
		for (int k = 0; k < 2; k++)
		begin
			// the typist waits for the carrier to settle first
			for (t = 0; ready !== 1'b1 || clk_n !== 1'b1; t++) step(1);
			kval = k ? 7'h2A : 7'h43;
			key_req = 1;
			step(1);
			key_req = 0;
			for (t = 0; clk_n !== 1'b0; t++) step(1);
			chk("data", data_n, 7'(~kval));
		end
		dir = 1;
		for (int i = 0; i < 7; i++)
		begin
			for (t = 0; clk_n !== 1'b1; t++) step(1);
			ch = chars[i];
			// old character can still show for a cycle
			clr_seen = 1;
			step(2);
			clr_seen = 0;
			for (t = 0; clk_n !== 1'b0; t++) step(1);
			chk("three_cycles", t > 120, exps[i][6]);
			chk("case_flag", ucf, exps[i][6]);
			chk("drivers", seen, exps[i][5:0]);
			if (exps[i][4])
				chk("coded", cap, code_map(ch));
		end
		print_verdict();
	end
endmodule : tb_top
